// ### logic/fan_tach_defs.svh
// constants for the fan tachometer monitor: offsets, fields, resets, counts
//
// Overview of operation
// - once enabled the tach counter is a 16-bit free-running counter
// - reading latches the counter on a read in pulse mode, or after 1, 2 or 4 pulses in tick mode
// - counter clears after a pulse-count latch and on reset
// - pulse mode counter steps on tach rising edges, tick mode counter on the 100 kHz tick strobe; registers use bus clock
// - clock request is inverse of sleep request, low while disabled
// - disable clears counters, reading value kept
// - system reset returns all state to defaults
// - one level interrupt output, high while an enabled cause is pending
// - pulse mode increments on each tach rising edge
// - pulse mode copies counter to reading on every increment
// - tick mode counts ticks, latches and clears after programmed pulses
// - count-ready status bit 3 sets on every pulse or tick latch into reading, not on a read latch
// - toggle status bit 2 sets on either tach edge
// - out-of-limit bit 0 sets when new reading is below low or above high
// - out-of-limit flag reaches interrupt only with control bit 0 set
// - low limit zero and high limit all ones suppress their events
// - mode bit 0 counts tach rising edges, 1 counts ticks
// - filter rejects tach pulses under three tick periods, default off
// - monitor enable clear gates the block and leaves the pin undriven
`ifndef FAN_TACH_DEFS_SVH
`define FAN_TACH_DEFS_SVH

// register byte offsets
`define OFF_CTRL      4'h0
`define OFF_STATUS    4'h4
`define OFF_HIGH      4'h8
`define OFF_LOW       4'hc

// control fields
`define CTRL_OOL_IE   0
`define CTRL_RUN      1
`define CTRL_FILT     8
`define CTRL_MODE     10
`define CTRL_EDGE_LO  11
`define CTRL_EDGE_HI  12
`define CTRL_RDY_IE   14
`define CTRL_TOG_IE   15

// status fields
`define STAT_OOL      0
`define STAT_TOG      2
`define STAT_RDY      3

// reset and limit values
`define CNT_ZERO      16'h0000
`define LIMIT_MAX     16'hffff
`define HIGH_RST      16'hffff
`define LOW_RST       16'h0000
`define DATA_ZERO     32'h0000_0000

// pulses per latch for each edges code
`define PULSES_1      3'h1
`define PULSES_2      3'h2
`define PULSES_4      3'h4
`define EDGES_1       2'h0
`define EDGES_2       2'h1

// filter width in slow ticks
`define FILT_TICKS    2'h3

// level of the tach pin on its pull-up
`define TACH_IDLE     1'b1

`endif

// ### logic/fan_tach_pkg.sv
// types for the fan tachometer monitor
`default_nettype none
package fan_tach_pkg;

    // whole state of the monitor core
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic        ool_ie;
        logic        run;
        logic        filt_en;
        logic        mode;
        logic [1:0]  edges;
        logic        rdy_ie;
        logic        tog_ie;
        logic [15:0] high;
        logic [15:0] low;
        logic [15:0] count;
        logic [15:0] reading;
        logic [2:0]  pulses;
        logic        st_ool;
        logic        st_tog;
        logic        st_rdy;
        logic        irq;
        logic        clk_req;
    } mon_state_t;

    // whole state of the input filter
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       level;
        logic [1:0] stable;
        logic       rise;
        logic       toggle;
    } filt_state_t;

endpackage
`default_nettype wire

// ### logic/tach_sig_if.sv
// carrier between the monitor core and its tach input filter
`default_nettype none
interface tach_sig_if;
    logic tick;
    logic filt_en;
    logic run;
    logic rise;
    logic toggle;

    modport filt (input tick, input filt_en, input run, output rise, output toggle);
    modport mon  (output tick, output filt_en, output run, input rise, input toggle);
endinterface
`default_nettype wire

// ### logic/tach_input_filter.sv
// tach pin synchroniser, glitch filter and edge detector
`include "fan_tach_defs.svh"
`default_nettype none
module tach_input_filter (
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // raw tach pin
    input  wire logic   tach_i,
    // to the monitor core
    tach_sig_if.filt    sig
);

    fan_tach_pkg::filt_state_t q;
    fan_tach_pkg::filt_state_t next_q;

    // filter and edges; sync1 feeds only sync2
    always_comb begin
        next_q        = q;
        next_q.sync1  = tach_i;
        next_q.sync2  = q.sync1;
        next_q.rise   = 1'b0;
        next_q.toggle = 1'b0;
        if (!sig.run) begin
            // idle: track the pin quietly so no stale edge appears on enable
            next_q.level  = q.sync2;
            next_q.stable = 2'h0;
        end else if (!sig.filt_en) begin
            next_q.level  = q.sync2;
            next_q.stable = 2'h0;
        end else if (q.sync2 == q.level) begin
            next_q.stable = 2'h0; // short pulse dropped, width restarts
        end else if (sig.tick) begin
            if (q.stable == `FILT_TICKS - 2'h1) begin
                next_q.level  = q.sync2;
                next_q.stable = 2'h0;
            end else begin
                next_q.stable = q.stable + 2'h1;
            end
        end
        if (sig.run && next_q.level != q.level) begin
            next_q.toggle = 1'b1;
            next_q.rise   = next_q.level;
        end
    end

    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q       <= '0;
            q.sync1 <= `TACH_IDLE; // pin rests high, so an early enable sees no false edge
            q.sync2 <= `TACH_IDLE;
            q.level <= `TACH_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign sig.rise   = q.rise;
    assign sig.toggle = q.toggle;

endmodule
`default_nettype wire

// ### logic/fan_tach_monitor.sv
// fan tachometer monitor core with avalon-mm register slave
//
// Decided for this implementation: the register addresses and register access over Avalon-MM.
`include "fan_tach_defs.svh"
`default_nettype none
module fan_tach_monitor (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // avalon-mm slave
    input  wire logic [3:0]    avs_address_i,
    input  wire logic          avs_read_i,
    input  wire logic          avs_write_i,
    input  wire logic [31:0]   avs_writedata_i,
    input  wire logic [3:0]    avs_byteenable_i,
    output logic [31:0]        avs_readdata_o,
    output logic               avs_waitrequest_o,
    // timing and power management
    input  wire logic          divided_tick_strobe_i,
    input  wire logic          sleep_request_in_i,
    output logic               clk_req_o,
    // fan tach pin, input only
    input  wire logic          tach_i,
    // interrupt
    output logic               irq_o
);

    // ************************************************************
    // state and input filter
    // ************************************************************

    fan_tach_pkg::mon_state_t q;
    fan_tach_pkg::mon_state_t next_q;

    tach_sig_if sig ();

    // filter follows the live control bits
    assign sig.tick    = divided_tick_strobe_i;
    assign sig.filt_en = q.filt_en;
    assign sig.run     = q.run;

    tach_input_filter u_filter (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tach_i(tach_i),
        .sig   (sig.filt)
    );

    // ************************************************************
    // helpers
    // ************************************************************

    // limit test with the two suppressing values
    function automatic logic limit_hit(input logic [15:0] v,
                                       input logic [15:0] hi,
                                       input logic [15:0] lo);
        logic below;
        logic above;
        below = (lo != `CNT_ZERO) && (v < lo);
        above = (hi != `LIMIT_MAX) && (v > hi);
        return below || above;
    endfunction

    // number of tach pulses per latch
    function automatic logic [2:0] pulse_target(input logic [1:0] code);
        logic [2:0] t;
        t = `PULSES_4;
        if (code == `EDGES_1) begin
            t = `PULSES_1;
        end else if (code == `EDGES_2) begin
            t = `PULSES_2;
        end
        return t;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************

    logic        req;
    logic [15:0] cnt_inc;
    logic [2:0]  pul_inc;
    logic        latch;
    logic [15:0] latch_val;

    always_comb begin
        next_q    = q;
        req       = avs_read_i || avs_write_i;
        cnt_inc   = q.count + 16'h1;
        pul_inc   = q.pulses + 3'h1;
        latch     = 1'b0;
        latch_val = q.reading;

        // bus: one wait cycle, then a one-cycle acknowledge
        if (!q.waitreq) begin
            next_q.waitreq = 1'b1;
            if (avs_write_i) begin
                if (avs_address_i == `OFF_CTRL) begin
                    if (avs_byteenable_i[0]) begin
                        next_q.ool_ie = avs_writedata_i[`CTRL_OOL_IE];
                        next_q.run    = avs_writedata_i[`CTRL_RUN];
                    end
                    if (avs_byteenable_i[1]) begin
                        next_q.filt_en = avs_writedata_i[`CTRL_FILT];
                        next_q.mode    = avs_writedata_i[`CTRL_MODE];
                        next_q.edges   = avs_writedata_i[`CTRL_EDGE_HI:`CTRL_EDGE_LO];
                        next_q.rdy_ie  = avs_writedata_i[`CTRL_RDY_IE];
                        next_q.tog_ie  = avs_writedata_i[`CTRL_TOG_IE];
                    end
                end else if (avs_address_i == `OFF_STATUS) begin
                    // write one to clear; a same-cycle event sets again below
                    if (avs_byteenable_i[0]) begin
                        if (avs_writedata_i[`STAT_OOL]) next_q.st_ool = 1'b0;
                        if (avs_writedata_i[`STAT_TOG]) next_q.st_tog = 1'b0;
                        if (avs_writedata_i[`STAT_RDY]) next_q.st_rdy = 1'b0;
                    end
                end else if (avs_address_i == `OFF_HIGH) begin
                    if (avs_byteenable_i[0]) next_q.high[7:0]  = avs_writedata_i[7:0];
                    if (avs_byteenable_i[1]) next_q.high[15:8] = avs_writedata_i[15:8];
                end else if (avs_address_i == `OFF_LOW) begin
                    if (avs_byteenable_i[0]) next_q.low[7:0]  = avs_writedata_i[7:0];
                    if (avs_byteenable_i[1]) next_q.low[15:8] = avs_writedata_i[15:8];
                end
            end
        end else if (req) begin
            next_q.waitreq = 1'b0;
            next_q.rdata   = `DATA_ZERO; // unmapped reads return zero
            if (avs_read_i) begin
                if (avs_address_i == `OFF_CTRL) begin
                    // pulse mode latches the live count on a read
                    if (q.run && !q.mode) begin
                        next_q.reading = q.count;
                    end
                    next_q.rdata = {(q.run && !q.mode) ? q.count : q.reading,
                                    q.tog_ie, q.rdy_ie, 1'b0, q.edges, q.mode,
                                    1'b0, q.filt_en, 6'h00, q.run, q.ool_ie};
                end else if (avs_address_i == `OFF_STATUS) begin
                    next_q.rdata = {28'h0000000, q.st_rdy, q.st_tog, 1'b0, q.st_ool};
                end else if (avs_address_i == `OFF_HIGH) begin
                    next_q.rdata = {16'h0000, q.high};
                end else if (avs_address_i == `OFF_LOW) begin
                    next_q.rdata = {16'h0000, q.low};
                end
            end
        end

        // counting; disabled means gated, counters held at zero
        if (!q.run) begin
            next_q.count  = `CNT_ZERO;
            next_q.pulses = 3'h0;
        end else if (!q.mode) begin
            // pulse mode: each tach rising edge steps and latches
            if (sig.rise) begin
                next_q.count = cnt_inc;
                latch        = 1'b1;
                latch_val    = cnt_inc;
            end
        end else begin
            // tick mode: count slow ticks between programmed pulses
            if (divided_tick_strobe_i) begin
                next_q.count = cnt_inc;
            end
            if (sig.rise) begin
                // at or past the target, so a smaller edges code still latches
                if (pul_inc >= pulse_target(q.edges)) begin
                    latch         = 1'b1;
                    latch_val     = q.count;
                    next_q.count  = `CNT_ZERO;
                    next_q.pulses = 3'h0;
                end else begin
                    next_q.pulses = pul_inc;
                end
            end
        end

        // event flags; sets come after the clears so a set wins
        if (latch) begin
            next_q.reading = latch_val;
            next_q.st_rdy  = 1'b1;
            if (limit_hit(latch_val, q.high, q.low)) begin
                next_q.st_ool = 1'b1;
            end
        end
        if (q.run && sig.toggle) begin
            next_q.st_tog = 1'b1;
        end

        // level interrupt from pending enabled causes
        next_q.irq = (q.st_ool && q.ool_ie)
                   || (q.st_tog && q.tog_ie)
                   || (q.st_rdy && q.rdy_ie);

        // clock request follows sleep only while enabled
        next_q.clk_req = q.run && !sleep_request_in_i;
    end

    // ************************************************************
    // state register
    // ************************************************************

    // all defaults on reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q         <= '0;
            q.waitreq <= 1'b1;
            q.high    <= `HIGH_RST;
            q.low     <= `LOW_RST;
        end else begin
            q <= next_q;
        end
    end

    // outputs straight from flops
    assign avs_readdata_o    = q.rdata;
    assign avs_waitrequest_o = q.waitreq;
    assign irq_o             = q.irq;
    assign clk_req_o         = q.clk_req;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // acknowledge lasts exactly one cycle
    a_ack_one_cycle:
        assert property (!q.waitreq |=> q.waitreq)
        else $error("waitrequest low for more than one cycle");

    // a fresh request is answered on the next edge
    a_req_answered:
        assert property ((avs_read_i || avs_write_i) && q.waitreq && $past(q.waitreq)
                         |=> !q.waitreq)
        else $error("request not acknowledged");

    a_pulse_step:
        assert property (q.run && !q.mode && sig.rise
                         |=> q.count == $past(q.count) + 16'h1)
        else $error("pulse mode count did not step");

    a_pulse_latch:
        assert property (q.run && !q.mode && sig.rise
                         |=> q.reading == q.count && q.st_rdy)
        else $error("pulse mode reading not latched");

    a_tick_step:
        assert property (q.run && q.mode && divided_tick_strobe_i && !sig.rise
                         |=> q.count == $past(q.count) + 16'h1)
        else $error("tick mode count did not step");

    a_disabled_clear:
        assert property (!q.run |=> q.count == `CNT_ZERO
                                    && q.reading == $past(q.reading))
        else $error("disabled counters not cleared or reading moved");

    a_clk_req_map:
        assert property (1'b1 |=> clk_req_o == ($past(q.run) && !$past(sleep_request_in_i)))
        else $error("clock request mismatch");

    a_irq_level:
        assert property (1'b1 |=> irq_o == (($past(q.st_ool) && $past(q.ool_ie))
                                         || ($past(q.st_tog) && $past(q.tog_ie))
                                         || ($past(q.st_rdy) && $past(q.rdy_ie))))
        else $error("interrupt level mismatch");

    a_toggle_flag:
        assert property (q.run && sig.toggle |=> q.st_tog)
        else $error("toggle status not set");

    a_low_limit:
        assert property ($rose(q.st_rdy) && q.low != `CNT_ZERO && q.reading < $past(q.low)
                         && $past(q.low) == q.low |-> q.st_ool)
        else $error("below-limit reading did not flag");

    // a high reading against a live high limit must flag
    a_high_limit:
        assert property ($rose(q.st_rdy) && q.high != `LIMIT_MAX && q.reading > $past(q.high)
                         && $past(q.high) == q.high |-> q.st_ool)
        else $error("above-limit reading did not flag");

    // suppressing limits never raise the out-of-limit flag
    a_limit_quiet:
        assert property ($rose(q.st_rdy) && !$past(q.st_ool) && q.low == `CNT_ZERO
                         && q.high == `LIMIT_MAX && $past(q.low) == q.low
                         && $past(q.high) == q.high |-> !q.st_ool)
        else $error("suppressed limit raised a flag");

    // a tick mode latch clears the counter and keeps the old count
    a_tick_latch:
        assert property (q.run && q.mode && sig.rise && pul_inc >= pulse_target(q.edges)
                         |=> q.count == `CNT_ZERO && q.reading == $past(q.count))
        else $error("tick mode latch missed");

    // every latch raises count-ready
    a_ready_on_latch:
        assert property (latch |=> q.st_rdy)
        else $error("count-ready not set on latch");

    // a control read in pulse mode latches the live count
    a_read_latch:
        assert property (avs_read_i && q.waitreq && avs_address_i == `OFF_CTRL
                         && q.run && !q.mode && !sig.rise |=> q.reading == $past(q.count))
        else $error("read did not latch the count");

    // a disabled monitor raises no toggle status
    a_idle_quiet:
        assert property (!q.run |=> !q.st_tog || $past(q.st_tog))
        else $error("toggle status set while disabled");

endmodule
`default_nettype wire

// ### test/fan_tach_model.sv
// behavioural fan model driving the tach pin of the monitor
`default_nettype none
module fan_tach_model (
    // bench clock
    input  wire logic clk_i,
    // tach pin seen by the monitor
    output logic      tach_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // the pin is pulled up, so it rests high between pulses
    initial tach_o = 1'b1;

    // each pulse is a low phase then a high phase; the rise ends the pulse
    // a short low phase is how the bench commands a glitch
    task automatic spin(input int n, input int lo, input int hi);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            tach_o <= 1'b0;
            repeat (lo) @(posedge clk_i);
            tach_o <= 1'b1;
            repeat (hi - 1) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the fan tachometer monitor
`default_nettype none
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic [3:0]  address = 4'h0;
    logic        rd      = 1'b0;
    logic        wr      = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic        tick    = 1'b0;
    logic        sleep   = 1'b0;
    logic [3:0]  be      = 4'hf;
    logic [6:0]  tick_cnt = 7'h00;
    logic [31:0] rdata, rdata_s, v;
    logic        wreq, irq, clk_req, tach, wreq_s, irq_s, req_s;
    logic [15:0] hl [4] = '{16'hffff, 16'h0005, 16'hffff, 16'h000a};
    logic [15:0] ll [4] = '{16'h0000, 16'h0000, 16'h0014, 16'h000a};
    logic [3:0]  ex      = 4'b0110;
    logic [3:0]  ie      = 4'b1011;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          p;

    // 10 MHz bench clock
    always #50 clk_i = ~clk_i;

    // 100 kHz tick strobe, one cycle in every hundred
    always @(posedge clk_i) begin
        tick_cnt <= (tick_cnt == 7'h63) ? 7'h00 : tick_cnt + 7'h01;
        tick     <= (tick_cnt == 7'h63);
    end

    // outputs are copied mid-cycle so the edge tests see settled values
    always @(negedge clk_i) begin
        wreq_s  = wreq;
        rdata_s = rdata;
        irq_s   = irq;
        req_s   = clk_req;
    end

    fan_tach_monitor fan_tach_monitor_i (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(address), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
        .divided_tick_strobe_i(tick), .sleep_request_in_i(sleep),
        .clk_req_o(clk_req), .tach_i(tach), .irq_o(irq)
    );

    fan_tach_model fan_tach_model_i (.clk_i(clk_i), .tach_o(tach));

    // ************************************************************
    // bus access and helpers
    // ************************************************************

    // request held until waitrequest is seen low; read data taken there
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        address <= a;
        wdata   <= d;
        rd      <= ~w;
        wr      <= w;
        do begin
            @(posedge clk_i);
            n++;
        end while (wreq_s !== 1'b0);
        `CHK("answer edges", 2, n)
        v  = rdata_s;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        `CHK(what, e, v)
    endtask

    // long enough for the synchroniser and the flag registers
    task automatic settle;
        repeat (12) @(posedge clk_i);
    endtask

    // keep tach edges half a tick away from the strobe
    task automatic align;
        @(posedge clk_i iff tick);
        repeat (50) @(posedge clk_i);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_reg(4'h0, 32'h0, "ctrl reset");
        chk_reg(4'h4, 32'h0, "status reset");
        chk_reg(4'h8, 32'h0000ffff, "high limit reset");
        chk_reg(4'hc, 32'h0, "low limit reset");
        chk_reg(4'h2, 32'h0, "unmapped read");
        `CHK("clk req disabled", 1'b0, req_s)
        // only the low byte lane of the high limit is written
        be <= 4'h1;
        wr_reg(4'h8, 32'h0000_1234);
        be <= 4'hf;
        chk_reg(4'h8, 32'h0000_ff34, "high limit lane");
        wr_reg(4'h8, 32'h0000_ffff);
        // pulse mode, toggle interrupt on
        wr_reg(4'h0, 32'h0000_8002);
        settle;
        `CHK("clk req awake", 1'b1, req_s)
        sleep <= 1'b1;
        settle;
        `CHK("clk req asleep", 1'b0, req_s)
        sleep <= 1'b0;
        fan_tach_model_i.spin(3, 40, 40);
        settle;
        chk_reg(4'h0, 32'h0003_8002, "pulse count");
        chk_reg(4'h4, 32'h0000_000c, "status flags");
        `CHK("irq toggle", 1'b1, irq_s)
        wr_reg(4'h4, 32'h0000_000f);
        chk_reg(4'h4, 32'h0, "status cleared");
        `CHK("irq cleared", 1'b0, irq_s)
        // disable keeps the reading but restarts the counter
        wr_reg(4'h0, 32'h0);
        settle;
        chk_reg(4'h0, 32'h0003_0000, "reading kept");
        `CHK("clk req idle", 1'b0, req_s)
        wr_reg(4'h0, 32'h0000_0002);
        fan_tach_model_i.spin(1, 40, 40);
        settle;
        chk_reg(4'h0, 32'h0001_0002, "count restart");
        // glitch filter: 1.5 ticks rejected, 5 ticks accepted
        wr_reg(4'h0, 32'h0000_0102);
        fan_tach_model_i.spin(1, 150, 500);
        settle;
        chk_reg(4'h0, 32'h0001_0102, "glitch rejected");
        fan_tach_model_i.spin(1, 500, 500);
        settle;
        chk_reg(4'h0, 32'h0002_0102, "pulse accepted");
        // tick mode, every edges code; pulses of 1000 cycles span 10 ticks
        for (int e = 0; e < 4; e++) begin
            p = (e == 0) ? 1 : (e == 1) ? 2 : 4;
            wr_reg(4'h0, 32'h0);
            wr_reg(4'h0, 32'h4402 | (32'(e) << 11));
            wr_reg(4'h4, 32'h0000_000f);
            align;
            fan_tach_model_i.spin(2 * p, 500, 500);
            settle;
            chk_reg(4'h0, {16'(10 * p), 16'h4402 | 16'(e << 11)},
                    "tick reading");
            bus(1'b0, 4'h4, 32'h0);
            `CHK("ready flag", 1'b1, v[3])
            `CHK("ready irq", 1'b1, irq_s)
        end
        // limit checks in tick mode, where they are meaningful
        for (int i = 0; i < 4; i++) begin
            wr_reg(4'h8, {16'h0, hl[i]});
            wr_reg(4'hc, {16'h0, ll[i]});
            wr_reg(4'h0, 32'h0402 | 32'(ie[i]));
            align;
            // the first latch holds a stale count, so its flags are cleared
            fork
                fan_tach_model_i.spin(2, 500, 500);
                begin
                    repeat (800) @(posedge clk_i);
                    wr_reg(4'h4, 32'h0000_000f);
                end
            join
            settle;
            bus(1'b0, 4'h4, 32'h0);
            `CHK("limit flag", ex[i], v[0])
            `CHK("limit irq", ex[i] & ie[i], irq_s)
        end
        // a reset in mid-run returns every register to its default
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk_reg(4'h0, 32'h0, "ctrl after reset");
        chk_reg(4'h8, 32'h0000ffff, "high after reset");
        `CHK("clk req after reset", 1'b0, req_s)
        report_and_stop;
    end

    // the sequence needs about 33000 cycles
    initial begin
        repeat (80000) @(posedge clk_i);
        bad_count++;
        $display("mismatch watchdog expected done seen timeout");
        report_and_stop;
    end
endmodule
`default_nettype wire
